//--- hw/dac_digital_mute_limiter.sv
// playback mute, polarity, auto mute, limiter and boost with APB registers
// assumes samples arrive one per sample period with valid/ready on pclk
module dac_digital_mute_limiter
    import dac_mute_limiter_pkg::*;
#(
    parameter int ZERO_RUN_LEN = ZERO_RUN
) (
    // apb
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    // sample input from the audio interface
    input  wire logic                in_valid,
    output logic                     in_ready,
    input  wire logic [SAMPLE_W-1:0] in_sample,
    // sample output to the interpolator
    output logic                     out_valid,
    input  wire logic                out_ready,
    output logic [SAMPLE_W-1:0]      out_sample,
    // status
    output logic                     auto_muted,
    output logic                     converter_enable
);
    initial begin
        if (ZERO_RUN_LEN < 2 || ZERO_RUN_LEN > 65535)
            $error("zero run length out of range");
    end

    typedef struct packed {
        logic [8:0]          pwr;
        logic [8:0]          conv;
        logic [8:0]          lim1;
        logic [8:0]          lim2;
        logic [31:0]         rdata;
        logic [15:0]         zero_cnt;
        logic                auto_mute_enable;
        logic [15:0]         mute_gain;
        logic [15:0]         lim_gain;
        logic                pend;
        logic [SAMPLE_W-1:0] res;
    } st_s;
    st_s st_reg, st_next;

    logic        acc, wr_en, rd_en, mapped;
    logic [7:0]  idx;
    logic        cv_en, lim_en, pol_inv, soft_mute, am_en;
    logic [3:0]  dcy, atk, boost_c;
    logic [2:0]  lvl_c;
    logic [2:0]  lvl;
    logic [3:0]  boost;
    logic        take, give;
    logic signed [SAMPLE_W-1:0]   s_in;
    logic        [SAMPLE_W-2:0]   mag;
    logic signed [GAIN_W:0]       g_tot;
    logic signed [SAMPLE_W+GAIN_W:0] prod;
    logic signed [SAMPLE_W+GAIN_W:0] scaled;
    logic signed [SAMPLE_W-1:0]   sat;
    logic        [SAMPLE_W-1:0]   neg_sat;
    logic [15:0] g_eff, gm_eff, atk_step, dcy_step;
    logic [15:0] boost_gain;
    logic [3:0]  atk_code, dcy_code;
    logic [31:0] gprod;

    // register decode: printed offsets are indices, byte address = 4*idx
    assign idx    = paddr[9:2];
    assign acc    = psel && penable;
    assign mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                    (idx == IDX_POWER_MGMT || idx == IDX_CONV_CTRL ||
                     idx == IDX_LIM_ONE || idx == IDX_LIM_TWO);
    assign wr_en  = acc && pwrite && mapped;
    assign rd_en  = psel && !penable && !pwrite;
    assign pready = 1'b1;          // zero wait states
    assign pslverr = acc && !mapped;
    assign prdata = st_reg.rdata;

    // control fields
    assign cv_en     = st_reg.pwr[BIT_CONV_EN];
    assign soft_mute = st_reg.conv[BIT_SOFT_MUTE];
    assign am_en     = st_reg.conv[BIT_AUTO_MUTE];
    assign pol_inv   = st_reg.conv[BIT_POL_INV];
    assign lim_en    = st_reg.lim1[BIT_LIM_EN];
    assign dcy       = st_reg.lim1[DCY_LSB +: 4];
    assign atk       = st_reg.lim1[3:0];
    assign lvl_c     = st_reg.lim2[LVL_LSB +: 3];
    assign boost_c   = st_reg.lim2[3:0];
    // codes 101..111 fold to -6dB, reserved boost codes clamp to +12dB
    assign lvl   = (lvl_c > 3'd5) ? 3'd5 : lvl_c;
    assign boost = (boost_c > BOOST_MAX) ? BOOST_MAX : boost_c;
    assign boost_gain = BOOST_TAB[boost];
    assign converter_enable = cv_en;
    assign auto_muted = st_reg.auto_mute_enable;

    // input buffer so a stalled interpolator loses no sample
    logic              b_valid, b_ready;
    logic [SAMPLE_W-1:0] b_data;
    sample_skid_buffer #(.WIDTH(SAMPLE_W)) u_buf (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   (in_sample),
        .out_valid (b_valid),
        .out_ready (b_ready),
        .out_data  (b_data)
    );

    // one result register; a disabled converter holds the path stalled
    assign b_ready   = cv_en && (!st_reg.pend || out_ready);
    assign take      = b_valid && b_ready;
    assign give      = st_reg.pend && out_ready;
    assign out_valid = st_reg.pend;
    assign out_sample = st_reg.res;

    // datapath: full 24-bit sample times combined gain, then saturate
    assign s_in = b_data;
    // limiter gain includes boost when enabled, else boost is fixed
    assign g_eff = lim_en ? st_reg.lim_gain : boost_gain;
    assign gprod = g_eff * st_reg.mute_gain;
    assign gm_eff = gprod[GAIN_FRAC +: 16];
    assign g_tot = {1'b0, gm_eff};
    assign prod  = s_in * g_tot;
    assign scaled = prod >>> GAIN_FRAC;
    always_comb begin
        if (scaled > (2**(SAMPLE_W-1)) - 1)
            sat = {1'b0, {(SAMPLE_W-1){1'b1}}};
        else if (scaled < -(2**(SAMPLE_W-1)))
            sat = {1'b1, {(SAMPLE_W-1){1'b0}}};
        else
            sat = scaled[SAMPLE_W-1:0];
    end
    // limiter level is measured after the gain, so a held loud input
    // settles inside the hysteresis band instead of driving gain to zero
    assign neg_sat = -sat;
    assign mag = !sat[SAMPLE_W-1] ? sat[SAMPLE_W-2:0] :
                 neg_sat[SAMPLE_W-1] ? {(SAMPLE_W-1){1'b1}} :
                 neg_sat[SAMPLE_W-2:0];

    // rate steps: each code doubles the time, codes 1011 and up share one
    assign atk_code = (atk > 4'(RATE_CODE_MAX)) ? 4'(RATE_CODE_MAX) : atk;
    assign dcy_code = (dcy > 4'(RATE_CODE_MAX)) ? 4'(RATE_CODE_MAX) : dcy;
    assign atk_step = st_reg.lim_gain >> (ATK_BASE_SHIFT + atk_code);
    assign dcy_step = st_reg.lim_gain >> (DCY_BASE_SHIFT + dcy_code);

    always_comb begin
        st_next = st_reg;
        // apb write in the access phase, read data latched in setup
        if (wr_en) begin
            case (idx)
                IDX_POWER_MGMT: st_next.pwr  = pwdata[REG_W-1:0];
                IDX_CONV_CTRL:  st_next.conv = pwdata[REG_W-1:0];
                IDX_LIM_ONE:    st_next.lim1 = pwdata[REG_W-1:0];
                IDX_LIM_TWO:    st_next.lim2 = pwdata[REG_W-1:0];
                default:        st_next.pwr  = st_reg.pwr;
            endcase
        end
        if (rd_en) begin
            case (idx)
                IDX_POWER_MGMT: st_next.rdata = {23'h0, st_reg.pwr};
                IDX_CONV_CTRL:  st_next.rdata = {23'h0, st_reg.conv};
                IDX_LIM_ONE:    st_next.rdata = {23'h0, st_reg.lim1};
                IDX_LIM_TWO:    st_next.rdata = {23'h0, st_reg.lim2};
                default:        st_next.rdata = 32'h0;
            endcase
            if (paddr[11:10] != 2'b00) st_next.rdata = 32'h0;
        end
        if (give) st_next.pend = 1'b0;
        if (take) begin
            st_next.pend = 1'b1;
            // auto mute counts zeros; a non-zero sample releases at once
            if (s_in != '0 || !am_en) begin
                st_next.zero_cnt = '0;
                st_next.auto_mute_enable    = 1'b0;
            end else if (st_reg.zero_cnt < 16'(ZERO_RUN_LEN - 1)) begin
                st_next.zero_cnt = st_reg.zero_cnt + 16'd1;
            end else begin
                st_next.auto_mute_enable = 1'b1;
            end
            // soft mute ramp, one step per sample, clamped
            if (soft_mute)
                st_next.mute_gain = (st_reg.mute_gain > MUTE_STEP) ?
                    st_reg.mute_gain - MUTE_STEP : 16'h0;
            else
                st_next.mute_gain = (st_reg.mute_gain <
                    GAIN_UNITY - MUTE_STEP) ?
                    st_reg.mute_gain + MUTE_STEP : GAIN_UNITY;
            // limiter gain tracking with one decibel of hysteresis
            if (mag > THR_HI_TAB[lvl] && st_reg.lim_gain > atk_step) begin
                st_next.lim_gain = st_reg.lim_gain - atk_step;
            end else if (mag < THR_LO_TAB[lvl]) begin
                st_next.lim_gain = (st_reg.lim_gain + dcy_step + 16'd1 <
                    boost_gain) ? st_reg.lim_gain + dcy_step + 16'd1 :
                    boost_gain;
            end
            if (!lim_en) st_next.lim_gain = boost_gain;
            // output: muted, polarity applied on the saturated value
            if (st_reg.auto_mute_enable && am_en && s_in == '0)
                st_next.res = '0;
            else if (pol_inv)
                st_next.res = (sat == {1'b1, {(SAMPLE_W-1){1'b0}}}) ?
                    {1'b0, {(SAMPLE_W-1){1'b1}}} : -sat;
            else
                st_next.res = sat;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg           <= '0;
            st_reg.pwr       <= RST_POWER_MGMT;
            st_reg.conv      <= RST_CONV_CTRL;
            st_reg.lim1      <= RST_LIM_ONE;
            st_reg.lim2      <= RST_LIM_TWO;
            st_reg.mute_gain <= GAIN_UNITY;
            st_reg.lim_gain  <= GAIN_UNITY;
        end else begin
            st_reg <= st_next;
        end
    end

    // no sample is taken from the buffer while the converter is disabled
    conv_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !cv_en |-> !take) else $error("sample taken while disabled");
    // held soft mute drives gain down monotonically
    mute_ramp_a: assert property (@(posedge pclk) disable iff (!presetn)
        (take && soft_mute) |=> st_reg.mute_gain <= $past(st_reg.mute_gain))
        else $error("soft mute gain rose");
    // ramp step bounded per sample
    ramp_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        take |=> (st_reg.mute_gain - $past(st_reg.mute_gain) <= MUTE_STEP ||
                  $past(st_reg.mute_gain) - st_reg.mute_gain <= MUTE_STEP))
        else $error("soft mute jump");
    // non-zero sample clears auto mute next cycle
    auto_mute_enable_rel_a: assert property (@(posedge pclk) disable iff (!presetn)
        (take && s_in != '0) |=> !st_reg.auto_mute_enable && st_reg.zero_cnt == 0)
        else $error("auto mute not released");
    // auto mute only with enable
    auto_mute_enable_en_a: assert property (@(posedge pclk) disable iff (!presetn)
        (take && !am_en) |=> !st_reg.auto_mute_enable)
        else $error("auto mute while disabled");
    // zero run reaching its length mutes
    auto_mute_enable_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (take && am_en && s_in == '0 &&
         st_reg.zero_cnt == 16'(ZERO_RUN_LEN - 1)) |=> st_reg.auto_mute_enable)
        else $error("auto mute missed");
    // limiter off means fixed boost gain
    boost_fix_a: assert property (@(posedge pclk) disable iff (!presetn)
        (take && !lim_en) |=> st_reg.lim_gain == $past(boost_gain))
        else $error("boost gain not fixed");
    // above upper threshold gain never rises
    atk_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
        (take && lim_en && mag > THR_HI_TAB[lvl]) |=>
        st_reg.lim_gain <= $past(st_reg.lim_gain))
        else $error("gain rose above threshold");
    // below lower threshold, limiter gain rises no higher than boost ceiling
    gain_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
        (take && lim_en && mag < THR_LO_TAB[lvl]) |=>
        st_reg.lim_gain <= $past(boost_gain))
        else $error("gain over ceiling");
endmodule

//--- hw/dac_mute_limiter_pkg.sv
// constants, register map and tables for the playback mute/limiter block
// assumes a 40 MHz pclk and samples arriving at the audio sample rate
// What this block does
// - filters and converter run only while converter enable (bit 0) is one
// - soft mute ramps gain to zero, release ramps back to programmed gain
// - samples carried at full 24-bit precision into the modulator path
// - output not inverted by default; polarity bit inverts it
// - auto mute mutes output after 1024 consecutive zero samples
// - a non-zero sample releases auto mute at once and restarts count
// - auto mute works only while bit 2 of converter control is one
// - boost zero: samples below upper threshold pass at unity gain
// - above upper threshold gain falls at attack rate until below
// - below lower threshold gain rises at decay rate back to 0dB
// - thresholds sit half a decibel above and below programmed level
// - level codes 000..100 give -1..-5dB, 101..111 give -6dB
// - boost adds 0..12dB in 1dB steps below threshold; above 12 reserved
// - with limiter off the boost is a fixed digital gain
// - limiter works only while bit 8 of limiter control one is one
// - decay time per 6dB doubles from 750us, codes 1011+ 1.536s, reset 0011
// - attack time per 6dB doubles from 94us, codes 1011+ 192ms, reset 0010
package dac_mute_limiter_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_POWER_MGMT = 8'h03;
    localparam logic [7:0] IDX_CONV_CTRL  = 8'h0A;
    localparam logic [7:0] IDX_LIM_ONE    = 8'h18;
    localparam logic [7:0] IDX_LIM_TWO    = 8'h19;
    localparam int         REG_W          = 9;
    // field positions
    localparam int BIT_CONV_EN   = 0;
    localparam int BIT_POL_INV   = 0;
    localparam int BIT_AUTO_MUTE = 2;
    localparam int BIT_SOFT_MUTE = 6;
    localparam int BIT_LIM_EN    = 8;
    localparam int DCY_LSB       = 4;
    localparam int LVL_LSB       = 4;
    // reset values
    localparam logic [8:0] RST_POWER_MGMT = 9'h000;
    localparam logic [8:0] RST_CONV_CTRL  = 9'h000;
    localparam logic [8:0] RST_LIM_ONE    = 9'h032;
    localparam logic [8:0] RST_LIM_TWO    = 9'h000;
    // sample and gain formats
    localparam int SAMPLE_W   = 24;
    localparam int GAIN_W     = 16;   // gain in Q4.12, unity = 4096
    localparam int GAIN_FRAC  = 12;
    localparam logic [15:0] GAIN_UNITY = 16'h1000;
    localparam logic [15:0] MUTE_STEP  = 16'h0020; // soft mute step per sample
    localparam int ZERO_RUN   = 1024;
    localparam int RATE_CODE_MAX = 11;
    localparam logic [3:0] BOOST_MAX = 4'hC;
    // base shift: per-sample gain step = gain >> (shift + code)
    localparam int ATK_BASE_SHIFT = 2;  // 94us ~ 4 samples per 6dB
    localparam int DCY_BASE_SHIFT = 5;  // 750us ~ 33 samples per 6dB
    // boost 0..12dB in Q4.12
    localparam logic [15:0] BOOST_TAB [13] = '{
        16'h1000, 16'h11F6, 16'h1429, 16'h16A2, 16'h1967, 16'h1C82,
        16'h1FFB, 16'h23E0, 16'h283C, 16'h2D1E, 16'h3298, 16'h38BE,
        16'h3FA6};
    // upper/lower thresholds of |sample| for levels -1..-6dB (24-bit FS)
    localparam logic [22:0] THR_HI_TAB [6] = '{
        23'h76E51B, 23'h69D33D, 23'h5E2A8A, 23'h53C2EA, 23'h4A76E1,
        23'h422DFD};
    localparam logic [22:0] THR_LO_TAB [6] = '{
        23'h6A9F1C, 23'h5EFB75, 23'h548B26, 23'h4B3305, 23'h42DA4D,
        23'h3B6A1D};
endpackage

//--- hw/sample_skid_buffer.sv
// two-entry valid/ready buffer for samples
// assumes producer and consumer on pclk
module sample_skid_buffer #(
    parameter int WIDTH = 24
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    initial begin
        if (WIDTH < 1) $error("width too small");
    end
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic [1:0]            count;
        logic                  rd;
        logic                  wr;
    } st_s;
    st_s st_reg, st_next;
    logic push, pop;
    assign in_ready  = st_reg.count != 2'd2;
    assign out_valid = st_reg.count != 2'd0;
    assign out_data  = st_reg.mem[st_reg.rd];
    assign push = in_valid && in_ready;
    assign pop  = out_valid && out_ready;
    // pointer storage; count moves only on unbalanced push/pop
    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wr] = in_data;
            st_next.wr = ~st_reg.wr;
        end
        if (pop) st_next.rd = ~st_reg.rd;
        if (push && !pop) st_next.count = st_reg.count + 2'd1;
        if (pop && !push) st_next.count = st_reg.count - 2'd1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) st_reg <= '0;
        else st_reg <= st_next;
    end
endmodule

//--- sim/audio_source.sv
// audio interface model: sends bursts of playback samples on request
// assumes the block's valid/ready stream input, all on pclk
module audio_source (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // burst control from the bench
    input  wire logic        go,
    input  wire logic [15:0] count,
    input  wire logic [23:0] base,
    input  wire logic [23:0] mask,
    input  wire logic [3:0]  gap,
    // sample stream
    input  wire logic        in_ready,
    output logic             in_valid,
    output logic [23:0]      in_sample,
    output logic             busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] left;
    logic [23:0] idx;
    logic [3:0]  hold;

    assign busy = (left != 16'h0);
    // hold each sample until taken, then idle for gap+1 cycles; the released
    // line shows the inverse so a stale value never passes for new data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_valid  <= 1'b0;
            in_sample <= 24'h000000;
            left      <= 16'h0000;
            idx       <= 24'h000000;
            hold      <= 4'h0;
        end else if (go) begin
            left <= count;
            hold <= gap;
        end else if (in_valid && in_ready) begin
            in_valid  <= 1'b0;
            in_sample <= ~in_sample;
            left      <= left - 16'h0001;
            hold      <= gap;
            idx       <= idx + 24'h000001;
        end else if (!in_valid && busy) begin
            if (hold != 4'h0) begin
                hold <= hold - 4'h1;
            end else begin
                in_valid  <= 1'b1;
                in_sample <= base + ((idx * 24'h00A3B1) & mask);
            end
        end
    end
endmodule

//--- sim/dac_digital_mute_limiter_tb.sv
// bench for the playback mute, polarity, auto mute and limiter block
// assumes the audio source model and a randomly stalling sink on pclk
module dac_digital_mute_limiter_tb
    import dac_mute_limiter_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        in_valid, in_ready, out_valid, out_ready, auto_muted;
    logic        converter_enable, go, err, ok;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic [23:0] in_sample, out_sample, base, mask, pk;
    logic [15:0] count;
    logic [3:0]  gap;
    logic [23:0] inq[$], outq[$];
    int          num_errors, tests_run, i;
    integer      seed = 32'hCA92E9B7;
    logic [11:0] adr [4] = '{12'h00C, 12'h028, 12'h060, 12'h064};
    logic [8:0]  rst [4] = '{9'h000, 9'h000, 9'h032, 9'h000};

    dac_digital_mute_limiter #(.ZERO_RUN_LEN(8)) u_dac_digital_mute_limiter (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
        .in_ready(in_ready), .in_sample(in_sample), .out_valid(out_valid),
        .out_ready(out_ready), .out_sample(out_sample),
        .auto_muted(auto_muted), .converter_enable(converter_enable));
    audio_source u_audio_source (
        .pclk(pclk), .presetn(presetn), .go(go), .count(count), .base(base),
        .mask(mask), .gap(gap), .in_ready(in_ready), .in_valid(in_valid),
        .in_sample(in_sample), .busy());

    // 40 MHz clock
    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;
    // record both sides of the stream; sink stalls one cycle in four
    always @(posedge pclk) begin
        if (in_valid && in_ready) inq.push_back(in_sample);
        if (out_valid && out_ready) outq.push_back(out_sample);
        out_ready <= ($random(seed) & 3) != 0;
    end

    task automatic end_of_test();
        if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check_val(logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // rounding of the gain product is left open, so allow one lsb
    task automatic check_near(logic [23:0] got, logic [23:0] exp);
        logic [23:0] e;
        e = (got === exp + 24'h1 || got === exp - 24'h1) ? got : exp;
        check_val(got, e);
    endtask
    // expected sample after a Q4.12 gain and optional inversion
    function automatic logic [23:0] gained(logic [23:0] x, logic [15:0] g,
                                           bit inv);
        longint p;
        p = (longint'($signed(x)) * longint'(g)) >>> 12;
        return inv ? 24'(-p) : 24'(p);
    endfunction
    // one apb transfer; read data and error kept in rd and err
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 50) begin
            num_errors++;
            end_of_test();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_out(int n);
        for (int k = 0; k < 20000 && outq.size() < n; k++) @(posedge pclk);
        if (outq.size() < n) begin
            num_errors++;
            end_of_test();
        end
        repeat (3) @(posedge pclk);
    endtask
    // start a burst of n samples, optionally wait until all come out
    task automatic run(int n, logic [23:0] b, logic [23:0] m, bit wt);
        inq.delete();
        outq.delete();
        @(posedge pclk);
        go    <= 1'b1;
        count <= 16'(n);
        base  <= b;
        mask  <= m;
        gap   <= 4'($random(seed) & 3);
        @(posedge pclk);
        go <= 1'b0;
        if (wt) wait_out(n);
    endtask
    task automatic cmp_q(int c, bit inv);
        check_val(outq.size(), inq.size());
        foreach (outq[k])
            check_near(outq[k], gained(inq[k], BOOST_TAB[c], inv));
    endtask
    // monotonic ramp with bounded steps, then the settled value
    task automatic ramp(bit up, logic [23:0] last);
        int d;
        ok = 1'b1;
        for (int k = 1; k < outq.size(); k++) begin
            d = $signed(outq[k]) - $signed(outq[k-1]);
            if ((up ? -d : d) > 0 || d > 32'sh2001 || d < -32'sh2001)
                ok = 1'b0;
        end
        check_val(ok, 1'b1);
        check_near(outq[$], last);
    endtask

    // main sequence
    initial begin
        {psel, penable, pwrite, go} = 4'b0000;
        {paddr, pwdata, count, base, mask, gap} = '0;
        presetn    = 1'b0;
        num_errors = 0;
        tests_run  = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 4; i++) begin
            apb(1'b0, adr[i], 32'h0);
            check_val(rd, 32'(rst[i]));
            v = $random(seed);
            apb(1'b1, adr[i], v);
            apb(1'b0, adr[i], 32'h0);
            check_val(rd, v & 32'h1FF);
            apb(1'b1, adr[i], 32'h0);
        end
        apb(1'b0, 12'h010, 32'h0);
        check_val(err, 1'b1);
        check_val(rd, 32'h0);
        // converter off: the buffer fills and nothing comes out
        run(5, 24'($random(seed)), 24'hFFFFFF, 1'b0);
        repeat (20) @(posedge pclk);
        check_val(in_ready, 1'b0);
        check_val(out_valid, 1'b0);
        apb(1'b1, 12'h00C, 32'h1);
        wait_out(5);
        check_val(converter_enable, 1'b1);
        cmp_q(0, 1'b0);
        apb(1'b1, 12'h028, 32'h1);
        run(20, 24'hE00000, 24'h3FFFFF, 1'b1);
        cmp_q(0, 1'b1);
        apb(1'b1, 12'h028, 32'h0);
        for (i = 0; i <= 12; i++) begin
            apb(1'b1, 12'h064, 32'(i));
            run(6, 24'hF80000, 24'h0FFFFF, 1'b1);
            cmp_q(i, 1'b0);
        end
        // zero runs just short of and at the mute length
        apb(1'b1, 12'h064, 32'h0);
        apb(1'b1, 12'h028, 32'h4);
        run(1, 24'h000005, 24'h0, 1'b1);
        run(7, 24'h0, 24'h0, 1'b1);
        check_val(auto_muted, 1'b0);
        run(1, 24'h0, 24'h0, 1'b1);
        check_val(auto_muted, 1'b1);
        run(1, 24'h012345, 24'h0, 1'b1);
        check_val(auto_muted, 1'b0);
        check_val(outq[0], 32'h012345);
        run(7, 24'h0, 24'h0, 1'b1);
        check_val(auto_muted, 1'b0);
        apb(1'b1, 12'h028, 32'h0);
        run(12, 24'h0, 24'h0, 1'b1);
        check_val(auto_muted, 1'b0);
        apb(1'b1, 12'h028, 32'h40);
        run(140, 24'h100000, 24'h0, 1'b1);
        ramp(1'b0, 24'h0);
        apb(1'b1, 12'h028, 32'h0);
        run(140, 24'h100000, 24'h0, 1'b1);
        ramp(1'b1, 24'h100000);
        // limiter at every level: full scale pulled down, then recovery
        for (i = 0; i < 8; i++) begin
            apb(1'b1, 12'h060, 32'h100);
            apb(1'b1, 12'h064, 32'(i) << 4);
            run(40, 24'h7FFFFF, 24'h0, 1'b1);
            pk = 24'h7FFFFF;
            foreach (outq[k]) if (outq[k] < pk) pk = outq[k];
            check_val(pk < THR_HI_TAB[i > 5 ? 5 : i], 1'b1);
            check_val(outq[39] < 24'h7FFFFF, 1'b1);
            check_val(outq[39] >= THR_LO_TAB[i > 5 ? 5 : i], 1'b1);
            run(200, 24'h100000, 24'h0, 1'b1);
            check_near(outq[199], 24'h100000);
        end
        apb(1'b1, 12'h060, 32'h0);
        run(4, 24'h7FFFFF, 24'h0, 1'b1);
        cmp_q(0, 1'b0);
        end_of_test();
    end
endmodule
